// ---- fsb_pkg.sv ----
// package for the fault status flag bank: offsets, field positions, reset values
// assumes an 8-bit register address and 8-bit data from the serial bus slave
package fsb_pkg;
  // ---------------------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] RAIL_FAULT_FLAGS_SECOND_OFS = 8'hB3;
  localparam logic [7:0] CRITICAL_TEMP_FLAGS_OFS = 8'hB4;
  localparam logic [7:0] HOT_TEMP_FLAGS_OFS = 8'hB5;
  localparam logic [7:0] OVERCURRENT_FLAGS_OFS = 8'hB6;

  // ---------------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] RAIL_FAULT_FLAGS_SECOND_RST = 8'h00;
  localparam logic [7:0] CRITICAL_TEMP_FLAGS_RST = 8'h00;
  localparam logic [7:0] HOT_TEMP_FLAGS_RST = 8'h00;
  localparam logic [7:0] OVERCURRENT_FLAGS_RST = 8'h00;

  // ---------------------------------------------------------------------------
  // field positions and implemented-bit masks
  // ---------------------------------------------------------------------------
  localparam int AUX_LINEAR_ONE_FAULT_BIT = 4;
  localparam int TERMINATION_REG_FAULT_BIT = 3;
  localparam int GROUP_B_CONV_TWO_FAULT_BIT = 2;
  localparam int GROUP_B_CONV_ONE_FAULT_BIT = 1;
  localparam int AUX_LINEAR_THREE_FAULT_BIT = 0;
  localparam int REST_DIE_SITE_BIT = 4;
  localparam int TERMINATION_REG_SITE_BIT = 3;
  localparam int UPPER_RIGHT_SITE_BIT = 2;
  localparam int UPPER_LEFT_SITE_BIT = 1;
  localparam int LOWER_RIGHT_SITE_BIT = 0;
  localparam int CONTROLLER_SIX_OC_BIT = 2;
  localparam int CONTROLLER_TWO_OC_BIT = 1;
  localparam int CONTROLLER_ONE_OC_BIT = 0;
  localparam int RAIL_FLAG_COUNT = 5;
  localparam int TEMP_SITE_COUNT = 5;
  localparam int OC_FLAG_COUNT = 3;
  localparam logic [7:0] RAIL_FAULT_MASK = 8'h1F;
  localparam logic [7:0] TEMP_SITE_MASK = 8'h1F;
  localparam logic [7:0] OVERCURRENT_MASK = 8'h07;

  // ---------------------------------------------------------------------------
  // timing: synchroniser depth in clock cycles
  // ---------------------------------------------------------------------------
  localparam int SYNC_STAGES = 2;
  // latency from monitor input change to flag set, in clock edges
  localparam int SET_LATENCY = 3;
endpackage : fsb_pkg

// ---- fsb_sync_bits.sv ----
// two-flop synchroniser for a vector of asynchronous monitor levels
// assumes inputs may change at any time relative to clk_in
module fsb_sync_bits #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // first stage is read only by the second stage
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule : fsb_sync_bits

// ---- fsb_flag_bank.sv ----
// sticky fault, temperature and overcurrent flag registers, write-one-to-clear
// assumes a serial bus slave outside presents one-cycle read and write strobes
// with an 8-bit register address and data, all synchronous to clk_in
module fsb_flag_bank (
  input wire logic clk_in,
  input wire logic rst_in,
  // register access from the serial bus slave
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_hit_out,
  // rail regulation loss monitors, high while out of regulation
  input wire logic aux_linear_one_fault_in,
  input wire logic termination_reg_fault_in,
  input wire logic group_b_conv_two_fault_in,
  input wire logic group_b_conv_one_fault_in,
  input wire logic aux_linear_three_fault_in,
  // temperature sensors, bit order: lower right, upper left, upper right, termination, rest of die
  input wire logic [4:0] site_critical_in,
  input wire logic [4:0] site_warm_in,
  // low-side switch overcurrent monitors
  input wire logic controller_six_overcurrent_in,
  input wire logic controller_two_overcurrent_in,
  input wire logic controller_one_overcurrent_in,
  // live view of the sticky flags for the alert logic elsewhere
  output logic [7:0] rail_fault_flags_second_out,
  output logic [7:0] critical_temp_flags_out,
  output logic [7:0] hot_temp_flags_out,
  output logic [7:0] overcurrent_flags_out
);
  // ---------------------------------------------------------------------------
  // input synchronisation
  // ---------------------------------------------------------------------------
  logic [17:0] raw_events;
  logic [17:0] sync_events;
  logic [7:0] rail_evt;
  logic [7:0] crit_evt;
  logic [7:0] hot_evt;
  logic [7:0] oc_evt;

  // monitors are analog comparators, asynchronous to clk_in
  assign raw_events = {controller_six_overcurrent_in, controller_two_overcurrent_in,
                       controller_one_overcurrent_in, site_warm_in, site_critical_in,
                       aux_linear_one_fault_in, termination_reg_fault_in,
                       group_b_conv_two_fault_in, group_b_conv_one_fault_in,
                       aux_linear_three_fault_in};

  fsb_sync_bits #(
    .WIDTH(18)
  ) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in(raw_events),
    .sync_out(sync_events)
  );

  // ---------------------------------------------------------------------------
  // event mapping onto register bit positions
  // ---------------------------------------------------------------------------
  always_comb begin
    rail_evt = 8'h00;
    crit_evt = 8'h00;
    hot_evt = 8'h00;
    oc_evt = 8'h00;
    rail_evt[fsb_pkg::AUX_LINEAR_THREE_FAULT_BIT] = sync_events[0];
    rail_evt[fsb_pkg::GROUP_B_CONV_ONE_FAULT_BIT] = sync_events[1];
    rail_evt[fsb_pkg::GROUP_B_CONV_TWO_FAULT_BIT] = sync_events[2];
    rail_evt[fsb_pkg::TERMINATION_REG_FAULT_BIT] = sync_events[3];
    rail_evt[fsb_pkg::AUX_LINEAR_ONE_FAULT_BIT] = sync_events[4];
    // each site drives one critical and one hot bit
    crit_evt[fsb_pkg::LOWER_RIGHT_SITE_BIT] = sync_events[5];
    crit_evt[fsb_pkg::UPPER_LEFT_SITE_BIT] = sync_events[6];
    crit_evt[fsb_pkg::UPPER_RIGHT_SITE_BIT] = sync_events[7];
    crit_evt[fsb_pkg::TERMINATION_REG_SITE_BIT] = sync_events[8];
    crit_evt[fsb_pkg::REST_DIE_SITE_BIT] = sync_events[9];
    hot_evt[fsb_pkg::LOWER_RIGHT_SITE_BIT] = sync_events[10];
    hot_evt[fsb_pkg::UPPER_LEFT_SITE_BIT] = sync_events[11];
    hot_evt[fsb_pkg::UPPER_RIGHT_SITE_BIT] = sync_events[12];
    hot_evt[fsb_pkg::TERMINATION_REG_SITE_BIT] = sync_events[13];
    hot_evt[fsb_pkg::REST_DIE_SITE_BIT] = sync_events[14];
    oc_evt[fsb_pkg::CONTROLLER_ONE_OC_BIT] = sync_events[15];
    oc_evt[fsb_pkg::CONTROLLER_TWO_OC_BIT] = sync_events[16];
    oc_evt[fsb_pkg::CONTROLLER_SIX_OC_BIT] = sync_events[17];
  end

  // ---------------------------------------------------------------------------
  // address decode and clear masks
  // ---------------------------------------------------------------------------
  logic sel_rail;
  logic sel_crit;
  logic sel_hot;
  logic sel_oc;
  logic [7:0] clr_rail;
  logic [7:0] clr_crit;
  logic [7:0] clr_hot;
  logic [7:0] clr_oc;

  assign sel_rail = reg_addr_in == fsb_pkg::RAIL_FAULT_FLAGS_SECOND_OFS;
  assign sel_crit = reg_addr_in == fsb_pkg::CRITICAL_TEMP_FLAGS_OFS;
  assign sel_hot = reg_addr_in == fsb_pkg::HOT_TEMP_FLAGS_OFS;
  assign sel_oc = reg_addr_in == fsb_pkg::OVERCURRENT_FLAGS_OFS;

  // zeros in the write data clear nothing; reserved lanes masked off
  assign clr_rail = (reg_wr_in && sel_rail) ? (reg_wdata_in & fsb_pkg::RAIL_FAULT_MASK) : 8'h00;
  assign clr_crit = (reg_wr_in && sel_crit) ? (reg_wdata_in & fsb_pkg::TEMP_SITE_MASK) : 8'h00;
  assign clr_hot = (reg_wr_in && sel_hot) ? (reg_wdata_in & fsb_pkg::TEMP_SITE_MASK) : 8'h00;
  assign clr_oc = (reg_wr_in && sel_oc) ? (reg_wdata_in & fsb_pkg::OVERCURRENT_MASK) : 8'h00;

  // ---------------------------------------------------------------------------
  // sticky flags
  // ---------------------------------------------------------------------------
  logic [7:0] rail_ff;
  logic [7:0] crit_ff;
  logic [7:0] hot_ff;
  logic [7:0] oc_ff;
  logic [7:0] nxt_rail;
  logic [7:0] nxt_crit;
  logic [7:0] nxt_hot;
  logic [7:0] nxt_oc;

  // set term is or-ed after the clear so a coincident event is never lost
  assign nxt_rail = ((rail_ff & ~clr_rail) | rail_evt) & fsb_pkg::RAIL_FAULT_MASK;
  assign nxt_crit = ((crit_ff & ~clr_crit) | crit_evt) & fsb_pkg::TEMP_SITE_MASK;
  assign nxt_hot = ((hot_ff & ~clr_hot) | hot_evt) & fsb_pkg::TEMP_SITE_MASK;
  assign nxt_oc = ((oc_ff & ~clr_oc) | oc_evt) & fsb_pkg::OVERCURRENT_MASK;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rail_ff <= fsb_pkg::RAIL_FAULT_FLAGS_SECOND_RST;
    end else begin
      rail_ff <= nxt_rail;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      crit_ff <= fsb_pkg::CRITICAL_TEMP_FLAGS_RST;
      hot_ff <= fsb_pkg::HOT_TEMP_FLAGS_RST;
    end else begin
      crit_ff <= nxt_crit;
      hot_ff <= nxt_hot;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      oc_ff <= fsb_pkg::OVERCURRENT_FLAGS_RST;
    end else begin
      oc_ff <= nxt_oc;
    end
  end

  // ---------------------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------------------
  logic [7:0] rdata_ff;
  logic hit_ff;
  logic [7:0] nxt_rdata;
  logic nxt_hit;

  always_comb begin
    nxt_rdata = 8'h00;
    nxt_hit = 1'b1;
    case (reg_addr_in)
      fsb_pkg::RAIL_FAULT_FLAGS_SECOND_OFS: nxt_rdata = rail_ff;
      fsb_pkg::CRITICAL_TEMP_FLAGS_OFS: nxt_rdata = crit_ff;
      fsb_pkg::HOT_TEMP_FLAGS_OFS: nxt_rdata = hot_ff;
      fsb_pkg::OVERCURRENT_FLAGS_OFS: nxt_rdata = oc_ff;
      default: nxt_hit = 1'b0;
    endcase
  end

  // data held from the last read so the serial shifter sees a stable byte
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_ff <= 8'h00;
      hit_ff <= 1'b0;
    end else if (reg_rd_in) begin
      rdata_ff <= nxt_rdata;
      hit_ff <= nxt_hit;
    end
  end

  assign reg_rdata_out = rdata_ff;
  assign reg_hit_out = hit_ff;
  assign rail_fault_flags_second_out = rail_ff;
  assign critical_temp_flags_out = crit_ff;
  assign hot_temp_flags_out = hot_ff;
  assign overcurrent_flags_out = oc_ff;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  // level seen on two edges in a row, so the synchroniser cannot miss it
  sequence s_held_two(lvl);
    lvl ##1 lvl;
  endsequence

  // level low at one edge, flag still clear two edges later
  sequence s_quiet_then_clear(lvl, flag);
    !lvl ##2 !flag;
  endsequence

  // overcurrent monitors in register bit order, for the loop below
  logic [2:0] oc_lvl;
  assign oc_lvl = {controller_six_overcurrent_in, controller_two_overcurrent_in, controller_one_overcurrent_in};

  a_rail_one_sets: assert property (@(posedge clk_in) disable iff (rst_in)
    s_held_two(aux_linear_one_fault_in) |-> ##2 rail_ff[4])
    else $error("aux linear one fault did not set bit 4");

  a_term_fault_sets: assert property (@(posedge clk_in) disable iff (rst_in)
    s_held_two(termination_reg_fault_in) |-> ##2 rail_ff[3])
    else $error("termination fault did not set bit 3");

  a_conv_two_sets: assert property (@(posedge clk_in) disable iff (rst_in)
    s_held_two(group_b_conv_two_fault_in) |-> ##2 rail_ff[2])
    else $error("converter two fault did not set bit 2");

  a_conv_one_sets: assert property (@(posedge clk_in) disable iff (rst_in)
    s_held_two(group_b_conv_one_fault_in) |-> ##2 rail_ff[1])
    else $error("converter one fault did not set bit 1");

  a_aux_three_sets: assert property (@(posedge clk_in) disable iff (rst_in)
    s_held_two(aux_linear_three_fault_in) |-> ##2 rail_ff[0])
    else $error("aux linear three fault did not set bit 0");

  a_rail_sticky: assert property (@(posedge clk_in) disable iff (rst_in)
    rail_ff[4] && !(reg_wr_in && sel_rail && reg_wdata_in[4]) |=> rail_ff[4])
    else $error("rail flag dropped without a clearing write");

  a_crit_die_sets: assert property (@(posedge clk_in) disable iff (rst_in)
    s_held_two(site_critical_in[4]) |-> ##2 critical_temp_flags_out[4])
    else $error("rest of die critical did not set bit 4");

  a_hot_corner_sets: assert property (@(posedge clk_in) disable iff (rst_in)
    s_held_two(site_warm_in[0]) |-> ##2 hot_temp_flags_out[0])
    else $error("lower right hot did not set bit 0");

  a_oc_six_sets: assert property (@(posedge clk_in) disable iff (rst_in)
    s_held_two(controller_six_overcurrent_in) |-> ##2 oc_ff[2])
    else $error("controller six overcurrent did not set bit 2");

  a_oc_clear_w1c: assert property (@(posedge clk_in) disable iff (rst_in)
    reg_wr_in && sel_oc && reg_wdata_in[0] && !sync_events[15] |=> !oc_ff[0])
    else $error("overcurrent flag not cleared by one-write");

  a_set_beats_clear: assert property (@(posedge clk_in) disable iff (rst_in)
    reg_wr_in && sel_crit && reg_wdata_in[1] && sync_events[6] |=> crit_ff[1])
    else $error("coincident event lost to clear");

  a_reserved_zero: assert property (@(posedge clk_in) disable iff (rst_in)
    rail_ff[7:5] == 3'h0 && crit_ff[7:5] == 3'h0 && hot_ff[7:5] == 3'h0 && oc_ff[7:3] == 5'h00)
    else $error("reserved bit read as one");

  a_read_returns: assert property (@(posedge clk_in) disable iff (rst_in)
    reg_rd_in && sel_hot |=> reg_rdata_out == $past(hot_ff) && reg_hit_out)
    else $error("hot register read returned wrong data");

  // the level two edges before decides; an earlier high may still be in flight
  a_sync_latency: assert property (@(posedge clk_in) disable iff (rst_in)
    s_quiet_then_clear(site_critical_in[3], crit_ff[3]) |=> !crit_ff[3])
    else $error("critical flag set without synchronised cause");

  // flags and the read holding register leave reset at their reset values
  a_reset_values: assert property (@(posedge clk_in) disable iff (rst_in)
    $fell(rst_in) |-> rail_ff == fsb_pkg::RAIL_FAULT_FLAGS_SECOND_RST &&
      crit_ff == fsb_pkg::CRITICAL_TEMP_FLAGS_RST && hot_ff == fsb_pkg::HOT_TEMP_FLAGS_RST &&
      oc_ff == fsb_pkg::OVERCURRENT_FLAGS_RST && rdata_ff == 8'h00 && !hit_ff)
    else $error("register not at its reset value after reset");

  // each site owns one critical and one hot flag
  for (genvar s = 0; s < fsb_pkg::TEMP_SITE_COUNT; s++) begin : g_site_chk
    a_crit_site_sets: assert property (@(posedge clk_in) disable iff (rst_in)
      s_held_two(site_critical_in[s]) |-> ##2 crit_ff[s])
      else $error("critical site level did not set its flag");

    a_hot_site_sets: assert property (@(posedge clk_in) disable iff (rst_in)
      s_held_two(site_warm_in[s]) |-> ##2 hot_ff[s])
      else $error("hot site level did not set its flag");

    a_crit_site_clears: assert property (@(posedge clk_in) disable iff (rst_in)
      reg_wr_in && sel_crit && reg_wdata_in[s] && !crit_evt[s] |=> !crit_ff[s])
      else $error("critical flag not cleared by one-write");

    a_hot_site_clears: assert property (@(posedge clk_in) disable iff (rst_in)
      reg_wr_in && sel_hot && reg_wdata_in[s] && !hot_evt[s] |=> !hot_ff[s])
      else $error("hot flag not cleared by one-write");

    a_crit_site_holds: assert property (@(posedge clk_in) disable iff (rst_in)
      crit_ff[s] && !(reg_wr_in && sel_crit && reg_wdata_in[s]) |=> crit_ff[s])
      else $error("critical flag dropped without a clearing write");

    a_hot_site_holds: assert property (@(posedge clk_in) disable iff (rst_in)
      hot_ff[s] && !(reg_wr_in && sel_hot && reg_wdata_in[s]) |=> hot_ff[s])
      else $error("hot flag dropped without a clearing write");
  end

  // every rail bit: sticky until its one-write, cleared by it when no fault remains
  for (genvar b = 0; b < fsb_pkg::RAIL_FLAG_COUNT; b++) begin : g_rail_chk
    a_rail_bit_holds: assert property (@(posedge clk_in) disable iff (rst_in)
      rail_ff[b] && !(reg_wr_in && sel_rail && reg_wdata_in[b]) |=> rail_ff[b])
      else $error("rail flag dropped without a clearing write");

    a_rail_bit_clears: assert property (@(posedge clk_in) disable iff (rst_in)
      reg_wr_in && sel_rail && reg_wdata_in[b] && !rail_evt[b] |=> !rail_ff[b])
      else $error("rail flag not cleared by one-write");
  end

  // every overcurrent bit: set by its monitor, sticky, cleared by its one-write
  for (genvar b = 0; b < fsb_pkg::OC_FLAG_COUNT; b++) begin : g_oc_chk
    a_oc_bit_sets: assert property (@(posedge clk_in) disable iff (rst_in)
      s_held_two(oc_lvl[b]) |-> ##2 oc_ff[b])
      else $error("overcurrent level did not set its flag");

    a_oc_bit_holds: assert property (@(posedge clk_in) disable iff (rst_in)
      oc_ff[b] && !(reg_wr_in && sel_oc && reg_wdata_in[b]) |=> oc_ff[b])
      else $error("overcurrent flag dropped without a clearing write");

    a_oc_bit_clears: assert property (@(posedge clk_in) disable iff (rst_in)
      reg_wr_in && sel_oc && reg_wdata_in[b] && !oc_evt[b] |=> !oc_ff[b])
      else $error("overcurrent flag not cleared by one-write");
  end
endmodule : fsb_flag_bank

// ---- fsb_host_model.sv ----
// host controller model: issues register reads and writes to the flag bank
// assumes one-cycle strobes taken at the rising edge and data valid one edge later
module fsb_host_model (
  input wire logic clk_in,
  input wire logic [7:0] reg_rdata_in,
  input wire logic reg_hit_in,
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic [7:0] reg_addr_out,
  output logic [7:0] reg_wdata_out
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_addr_out = 8'h5A;
    reg_wdata_out = 8'hA5;
  end

  // ---------------------------------------------------------------------------
  // bus cycles
  // ---------------------------------------------------------------------------
  // ones in d clear flags; idle lines show the inverse so stale values never match
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    #1;
    reg_wr_out = 1'b1;
    reg_addr_out = a;
    reg_wdata_out = d;
    @(posedge clk_in);
    #1;
    reg_wr_out = 1'b0;
    reg_addr_out = ~a;
    reg_wdata_out = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
    @(posedge clk_in);
    #1;
    reg_rd_out = 1'b1;
    reg_addr_out = a;
    @(posedge clk_in);
    #1;
    d = reg_rdata_in;
    h = reg_hit_in;
    reg_rd_out = 1'b0;
    reg_addr_out = ~a;
  endtask : rd
endmodule : fsb_host_model

// ---- fsb_flag_bank_test.sv ----
// self-checking bench for the sticky flag bank, with an integer model of the flags
// assumes the host model for register access and monitor levels driven directly
module fsb_flag_bank_test;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk_in, rst_in, reg_wr, reg_rd, hit, h;
  logic [7:0] addr, wdata, rdata, r;
  logic [7:0] mon [4];
  logic [7:0] live [4];
  int exp_q [4];
  int fails, n_tests, cycles;
  int i, k;
  logic [7:0] v, w;

  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  fsb_flag_bank dut (
    .clk_in(clk_in), .rst_in(rst_in), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_hit_out(hit),
    .aux_linear_one_fault_in(mon[0][4]), .termination_reg_fault_in(mon[0][3]),
    .group_b_conv_two_fault_in(mon[0][2]), .group_b_conv_one_fault_in(mon[0][1]),
    .aux_linear_three_fault_in(mon[0][0]), .site_critical_in(mon[1][4:0]),
    .site_warm_in(mon[2][4:0]), .controller_six_overcurrent_in(mon[3][2]),
    .controller_two_overcurrent_in(mon[3][1]), .controller_one_overcurrent_in(mon[3][0]),
    .rail_fault_flags_second_out(live[0]), .critical_temp_flags_out(live[1]),
    .hot_temp_flags_out(live[2]), .overcurrent_flags_out(live[3])
  );

  fsb_host_model host (
    .clk_in(clk_in), .reg_rdata_in(rdata), .reg_hit_in(hit), .reg_wr_out(reg_wr),
    .reg_rd_out(reg_rd), .reg_addr_out(addr), .reg_wdata_out(wdata)
  );

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  function automatic logic [7:0] msk(int n);
    case (n)
      0: return fsb_pkg::RAIL_FAULT_MASK;
      1, 2: return fsb_pkg::TEMP_SITE_MASK;
      default: return fsb_pkg::OVERCURRENT_MASK;
    endcase
  endfunction : msk

  // the four flag registers sit at consecutive offsets
  function automatic logic [7:0] ofs(int n);
    return fsb_pkg::RAIL_FAULT_FLAGS_SECOND_OFS + 8'(n);
  endfunction : ofs

  task automatic cmp8(string what, logic [7:0] e, logic [7:0] s);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, e, s);
    end
  endtask : cmp8

  task automatic cmp1(string what, logic e, logic s);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %b seen %b", what, e, s);
    end
  endtask : cmp1

  task automatic rd_chk(int n);
    host.rd(ofs(n), r, h);
    cmp8("read flags", 8'(exp_q[n]), r);
    cmp1("read hit", 1'b1, h);
    cmp8("live flags", 8'(exp_q[n]), live[n]);
  endtask : rd_chk

  // held three edges so the synchroniser cannot miss it, then released
  task automatic pulse(int n, logic [7:0] val);
    @(posedge clk_in);
    #1;
    mon[n] = val;
    repeat (3) @(posedge clk_in);
    #1;
    mon[n] = 8'h00;
    repeat (3) @(posedge clk_in);
    exp_q[n] = exp_q[n] | int'(val & msk(n));
  endtask : pulse

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  // ---------------------------------------------------------------------------
  // timeout: the sequence needs well under 2000 cycles
  // ---------------------------------------------------------------------------
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      end_of_test;
    end
  end

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    void'($urandom(32'hBED65606));
    rst_in = 1'b1;
    for (i = 0; i < 4; i++) begin
      mon[i] = 8'h00;
      exp_q[i] = 0;
    end
    repeat (20) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    for (i = 0; i < 4; i++) rd_chk(i);
    // latency: nothing after two edges, flag after the third
    @(posedge clk_in);
    #1;
    mon[0] = 8'h10;
    repeat (2) @(posedge clk_in);
    #1;
    cmp8("rail early", 8'h00, live[0]);
    @(posedge clk_in);
    #1;
    cmp8("rail set", 8'h10, live[0]);
    exp_q[0] = 'h10;
    host.wr(ofs(0), 8'hFF);
    rd_chk(0);
    @(posedge clk_in);
    #1;
    mon[0] = 8'h00;
    repeat (3) @(posedge clk_in);
    host.wr(ofs(0), 8'hEF);
    rd_chk(0);
    host.wr(ofs(0), 8'hFF);
    exp_q[0] = 0;
    rd_chk(0);
    // unmapped places neither clear nor answer
    pulse(3, 8'hFF);
    host.wr(8'hB7, 8'hFF);
    host.wr(8'hB2, 8'hFF);
    rd_chk(3);
    for (k = 0; k < 4; k++) begin
      v = (k == 0) ? 8'hB2 : (k == 1) ? 8'hB7 : (k == 2) ? 8'h00 : 8'hFF;
      host.rd(v, r, h);
      cmp8("unmapped data", 8'h00, r);
      cmp1("unmapped hit", 1'b0, h);
    end
    // random events and random clearing writes over all four registers
    for (k = 0; k < 32; k++) begin
      i = $urandom_range(3, 0);
      v = 8'($urandom);
      w = 8'($urandom);
      pulse(i, v);
      rd_chk(i);
      host.wr(ofs(i), w);
      exp_q[i] = exp_q[i] & ~int'(w);
      rd_chk(i);
    end
    // every flag set, then a reset in mid-run must drop them all
    for (i = 0; i < 4; i++) pulse(i, 8'hFF);
    for (i = 0; i < 4; i++) rd_chk(i);
    @(posedge clk_in);
    #1;
    rst_in = 1'b1;
    repeat (2) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    cmp8("rdata after reset", 8'h00, rdata);
    cmp1("hit after reset", 1'b0, hit);
    for (i = 0; i < 4; i++) begin
      exp_q[i] = 0;
      rd_chk(i);
    end
    // a critical level still present wins against a clearing write
    @(posedge clk_in);
    #1;
    mon[1] = 8'h02;
    repeat (3) @(posedge clk_in);
    host.wr(ofs(1), 8'hFF);
    exp_q[1] = 'h02;
    rd_chk(1);
    mon[1] = 8'h00;
    repeat (3) @(posedge clk_in);
    host.wr(ofs(1), 8'h02);
    exp_q[1] = 0;
    rd_chk(1);
    end_of_test;
  end
endmodule : fsb_flag_bank_test
